// ---- lcd_port_defines.svh ----
`ifndef LCD_PORT_DEFINES_SVH
`define LCD_PORT_DEFINES_SVH

`define CLK_PERIOD_NS 40
`define RESET_TIME_NS 1000
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INSTR_TIME_NS 80
`define INSTR_CYCLES ((`INSTR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define PAGES 8
`define COLUMNS 64
`define FIFO_DEPTH 16

`define STAT_BUSY_BIT 7
`define STAT_OFF_BIT 5
`define STAT_RESET_BIT 4

`define START_LINE_RESET 6'h00
`define DISPLAY_OFF_RESET 1'b1

`define OP_ONOFF_MASK 8'hFE
`define OP_ONOFF_CODE 8'h3E
`define OP_YADDR_MASK 8'hC0
`define OP_YADDR_CODE 8'h40
`define OP_PAGE_MASK 8'hF8
`define OP_PAGE_CODE 8'hB8
`define OP_LINE_MASK 8'hC0
`define OP_LINE_CODE 8'hC0

`endif

// ---- lcd_port_pkg.sv ----
package lcd_port_pkg;
  typedef enum logic [1:0] {ACC_INSTR, ACC_STATUS, ACC_WRITE, ACC_READ} access_e;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] col_t;
  typedef logic [2:0] page_t;
endpackage : lcd_port_pkg

// ---- word_fifo.sv ----
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("word_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign in_ready_out = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                        (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign out_data_out = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  no_overflow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !in_ready_out && !pop |=> !in_ready_out)
    else $error("fifo full flag dropped without a pop");
endmodule : word_fifo

// ---- lcd_host_port.sv ----
`timescale 1ns/10ps
`include "lcd_port_defines.svh"

// Notes on behaviour
// R1: Unselected chip ignores accesses, state unchanged
// R2: Init pin, column order work unselected
// R3: Write byte captured on strobe fall, moved later
// R4: Select and read/write decode four access types
// R5: Data read returns old byte, then reloads
// R6: Status read valid on first access
// R7: Init pin low starts reset sequence
// R8: Reset turns display off, start line zero
// R9: During reset only status reads accepted
// R10: Status bit 7 high while busy
// R11: Status bit 5 off, bit 4 reset
// R12: Busy from strobe fall until work done
module lcd_host_port #(
  parameter int RESET_CYCLES = `RESET_CYCLES,
  parameter int INSTR_CYCLES = `INSTR_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host bus
  input wire logic chip_sel_a_n_in,
  input wire logic chip_sel_b_n_in,
  input wire logic chip_sel_c_in,
  input wire logic reg_or_data_sel_in,
  input wire logic read_not_write_in,
  input wire logic strobe_in,
  input wire lcd_port_pkg::byte_t host_data_bus_in,
  output lcd_port_pkg::byte_t host_data_bus_out,
  output logic host_data_bus_oe_n_out,
  // Board pins
  input wire logic init_pin_n_in,
  input wire logic col_order_in,
  // Display scan
  input wire lcd_port_pkg::page_t scan_page_in,
  input wire lcd_port_pkg::col_t scan_col_in,
  output lcd_port_pkg::byte_t seg_data_out,
  // State
  output logic display_off_out,
  output lcd_port_pkg::col_t start_line_out,
  output logic busy_out,
  output logic in_reset_out
);
  import lcd_port_pkg::*;

  localparam int FW = 17;

  generate
    if (RESET_CYCLES < 2 || RESET_CYCLES > 255 || INSTR_CYCLES < 1 ||
        INSTR_CYCLES > 255) begin : g_bad
      $error("lcd_host_port: reset count must lie in 2..255, instruction count in 1..255");
    end
  endgenerate

  function automatic access_e decode_access(input logic rs, input logic rw);
    access_e a;
    a = ACC_INSTR;
    unique case ({rs, rw})
      2'b00: a = ACC_INSTR;
      2'b01: a = ACC_STATUS;
      2'b10: a = ACC_WRITE;
      2'b11: a = ACC_READ;
    endcase
    return a;
  endfunction : decode_access

  // Display memory, one byte per page and column
  byte_t ram [`PAGES * `COLUMNS];

  logic strobe_prev_reg;
  logic in_reset_reg;
  logic [7:0] reset_cnt_reg;
  logic [7:0] exec_cnt_reg;
  logic display_off_reg;
  col_t start_line_reg;
  page_t page_reg;
  col_t y_reg;
  byte_t out_reg;
  byte_t bus_out_reg;
  logic bus_oe_n_reg;
  byte_t seg_reg;
  logic busy_reg;

  logic selected;
  logic strobe_fall;
  logic take;
  access_e acc;
  logic cmd_ok;
  logic instr_take;
  logic wr_take;
  logic rd_take;
  byte_t status_byte;
  byte_t ram_at_cursor;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;

  assign selected = !chip_sel_a_n_in && !chip_sel_b_n_in && chip_sel_c_in; // [R1]
  assign strobe_fall = strobe_prev_reg && !strobe_in;
  assign take = strobe_fall && selected; // [R1]
  assign acc = decode_access(reg_or_data_sel_in, read_not_write_in); // [R4]
  assign cmd_ok = take && !in_reset_reg; // [R9]
  assign instr_take = cmd_ok && acc == ACC_INSTR;
  assign wr_take = cmd_ok && acc == ACC_WRITE && fifo_in_ready;
  assign rd_take = cmd_ok && acc == ACC_READ;
  assign ram_at_cursor = ram[{page_reg, y_reg}];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= strobe_in;
    end
  end

  // Reset flag held at least the minimum reset time past init release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      in_reset_reg <= 1'b1;
      reset_cnt_reg <= 8'h00;
    end else if (!init_pin_n_in) begin
      in_reset_reg <= 1'b1; // [R7] [R2]
      reset_cnt_reg <= 8'h00;
    end else if (in_reset_reg) begin
      if (reset_cnt_reg == 8'(RESET_CYCLES - 1)) begin
        in_reset_reg <= 1'b0;
      end
      reset_cnt_reg <= reset_cnt_reg + 8'h01;
    end
  end

  // Display on/off and start line
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !init_pin_n_in) begin
      display_off_reg <= `DISPLAY_OFF_RESET; // [R8] [R2]
      start_line_reg <= `START_LINE_RESET; // [R8]
    end else if (instr_take) begin
      if ((host_data_bus_in & `OP_ONOFF_MASK) == `OP_ONOFF_CODE) begin
        display_off_reg <= !host_data_bus_in[0]; // [R4]
      end
      if ((host_data_bus_in & `OP_LINE_MASK) == `OP_LINE_CODE) begin
        start_line_reg <= host_data_bus_in[5:0];
      end
    end
  end

  // Page and column cursor
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      page_reg <= '0;
      y_reg <= '0;
    end else if (instr_take) begin
      if ((host_data_bus_in & `OP_PAGE_MASK) == `OP_PAGE_CODE) begin
        page_reg <= host_data_bus_in[2:0];
      end
      if ((host_data_bus_in & `OP_YADDR_MASK) == `OP_YADDR_CODE) begin
        y_reg <= host_data_bus_in[5:0];
      end
    end else if (wr_take || rd_take) begin
      y_reg <= y_reg + 6'h01; // [R3] [R5]
    end
  end

  // Instruction execution time
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      exec_cnt_reg <= 8'h00;
    end else if (instr_take) begin
      exec_cnt_reg <= 8'(INSTR_CYCLES); // [R12]
    end else if (exec_cnt_reg != 8'h00) begin
      exec_cnt_reg <= exec_cnt_reg - 8'h01;
    end
  end

  // Written bytes wait here with their address until the memory takes them
  assign fifo_in_valid = cmd_ok && acc == ACC_WRITE; // [R3]
  assign fifo_out_ready = !rd_take;

  word_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(fifo_in_valid),
    .in_data_in({page_reg, y_reg, host_data_bus_in}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  always_ff @(posedge clk_in) begin
    if (fifo_out_valid && fifo_out_ready) begin
      ram[fifo_out_data[16:8]] <= fifo_out_data[7:0]; // [R3]
    end
  end

  // Output register reloads after each data read, hence the dummy read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_reg <= 8'h00;
    end else if (rd_take) begin
      out_reg <= ram_at_cursor; // [R5]
    end
  end

  // Busy lags the strobe fall by one clock; conservative by one at the end of a write, exact for an instruction
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b1;
    end else begin
      busy_reg <= in_reset_reg || exec_cnt_reg > 8'h01 || instr_take ||
                  fifo_in_valid || fifo_out_valid; // [R12] [R10]
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`STAT_BUSY_BIT] = busy_reg; // [R10]
    status_byte[`STAT_OFF_BIT] = display_off_reg; // [R11]
    status_byte[`STAT_RESET_BIT] = in_reset_reg; // [R11]
  end

  // Bus drive while the strobe is high on a selected read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_out_reg <= 8'h00;
      bus_oe_n_reg <= 1'b1;
    end else begin
      bus_out_reg <= (acc == ACC_STATUS) ? status_byte : out_reg; // [R6] [R5]
      bus_oe_n_reg <= !(strobe_in && selected && read_not_write_in &&
                        (acc == ACC_STATUS || !in_reset_reg)); // [R1] [R9]
    end
  end

  // Scan port honours column order regardless of selection
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seg_reg <= 8'h00;
    end else if (display_off_reg) begin
      seg_reg <= 8'h00;
    end else begin
      seg_reg <= ram[{scan_page_in, col_order_in ? scan_col_in : ~scan_col_in}]; // [R2]
    end
  end

  assign host_data_bus_out = bus_out_reg;
  assign host_data_bus_oe_n_out = bus_oe_n_reg;
  assign seg_data_out = seg_reg;
  assign display_off_out = display_off_reg;
  assign start_line_out = start_line_reg;
  assign busy_out = busy_reg;
  assign in_reset_out = in_reset_reg;

  // Independent count of cycles since init release, for the hold check
  logic [7:0] since_init_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !init_pin_n_in) begin
      since_init_reg <= 8'h00;
    end else if (since_init_reg != 8'hFF) begin
      since_init_reg <= since_init_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  unselected_ignored_a: assert property ( // [R1]
    !selected && strobe_fall && init_pin_n_in
    |=> $stable(display_off_reg) && $stable(y_reg) && $stable(page_reg))
    else $error("unselected access changed state");

  init_clears_a: assert property ( // [R8]
    !init_pin_n_in |=> display_off_out && start_line_out == 6'h00 && in_reset_out)
    else $error("init pin did not turn display off or clear start line");

  reset_hold_a: assert property ( // [R7]
    since_init_reg < 8'(RESET_CYCLES) |-> in_reset_reg)
    else $error("reset flag cleared too early");

  reset_ends_a: assert property ( // [R7]
    since_init_reg == 8'(RESET_CYCLES) |-> !in_reset_reg)
    else $error("reset flag held too long");

  write_capture_a: assert property ( // [R3]
    wr_take |=> y_reg == 6'($past(y_reg) + 6'h01) && fifo_out_valid)
    else $error("written byte not captured");

  write_busy_a: assert property ( // [R12]
    wr_take |=> busy_out [*2])
    else $error("busy not raised after write");

  onoff_decode_a: assert property ( // [R4]
    instr_take && host_data_bus_in == 8'h3F |=> !display_off_out)
    else $error("display on instruction not decoded");

  read_reload_a: assert property ( // [R5]
    rd_take |=> out_reg == $past(ram_at_cursor))
    else $error("output register not reloaded on data read");

  status_direct_a: assert property ( // [R6]
    strobe_in && selected && read_not_write_in && !reg_or_data_sel_in
    |=> !host_data_bus_oe_n_out && host_data_bus_out == $past(status_byte))
    else $error("status not presented on first access");

  reset_only_status_a: assert property ( // [R9]
    in_reset_reg && take && acc != ACC_STATUS |=> $stable(y_reg) && $stable(page_reg))
    else $error("command accepted during reset");

  status_bits_a: assert property ( // [R11]
    !init_pin_n_in ##1 init_pin_n_in |=> status_byte[4] && status_byte[7] && status_byte[5])
    else $error("status bits wrong after init");

  busy_instr_a: assert property ( // [R10]
    instr_take |=> busy_out ##1 busy_out)
    else $error("busy not shown during instruction");

  write_cov: cover property (wr_take ##[1:20] !busy_out);
  read_cov: cover property (rd_take ##[2:30] rd_take);
  status_cov: cover property (take && acc == ACC_STATUS && in_reset_reg);
  instr_cov: cover property (instr_take ##[1:10] !busy_out);
endmodule : lcd_host_port

// ---- host_bus_model.sv ----
`timescale 1ns/10ps
module host_bus_model (
  // Clock
  input wire logic clk_in,
  // Bus towards the device
  output logic sel_a_n_out,
  output logic sel_b_n_out,
  output logic sel_c_out,
  output logic rs_out,
  output logic rw_out,
  output logic strobe_out,
  output lcd_port_pkg::byte_t bus_out,
  input wire lcd_port_pkg::byte_t dev_data_in,
  input wire logic dev_oe_n_in
);
  import lcd_port_pkg::*;
  logic drive_reg = 1'b0;
  byte_t hd_reg = 8'h00;
  byte_t last_reg = 8'h00;
  // Nobody driving: inverse of last level, so stale data never passes
  assign bus_out = !dev_oe_n_in ? dev_data_in : (drive_reg ? hd_reg : ~last_reg);
  always @(posedge clk_in) last_reg <= bus_out;
  initial begin
    {sel_a_n_out, sel_b_n_out, sel_c_out} = 3'h6;
    {rs_out, rw_out, strobe_out} = 3'h0;
  end
  // Strobe two clocks high, at least three low; controls held past the fall
  task automatic access(input logic [2:0] sel, input logic rs, input logic rw,
                        input byte_t d, output byte_t q);
    @(posedge clk_in);
    {sel_a_n_out, sel_b_n_out, sel_c_out} <= sel;
    rs_out <= rs;
    rw_out <= rw;
    hd_reg <= d;
    drive_reg <= !rw;
    strobe_out <= 1'b1;
    @(posedge clk_in);
    // Read data settled mid-cycle, away from the launching edge
    @(negedge clk_in);
    q = bus_out;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    {sel_a_n_out, sel_b_n_out, sel_c_out} <= 3'h6;
    drive_reg <= 1'b0;
  endtask : access
  task automatic wait_ready(output logic ok);
    byte_t s;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      access(3'h1, 1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0) && (s[4] === 1'b0);
    end
  endtask : wait_ready
endmodule : host_bus_model

// ---- lcd_host_port_tb_top.sv ----
`timescale 1ns/10ps
module lcd_host_port_tb_top;
  import lcd_port_pkg::*;
  logic clk, rst_n, init_n, col_order, sa, sb, sc, rs, rw, strb, oe_n, off, busy, inrst;
  page_t spage;
  col_t scol, sline;
  byte_t bus, dout, seg, q;
  int miscompares = 0;
  int compares = 0;
  lcd_host_port #(.RESET_CYCLES(2)) u_dut (.clk_in(clk), .rst_n_in(rst_n),
    .chip_sel_a_n_in(sa), .chip_sel_b_n_in(sb), .chip_sel_c_in(sc),
    .reg_or_data_sel_in(rs), .read_not_write_in(rw), .strobe_in(strb),
    .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_n_out(oe_n),
    .init_pin_n_in(init_n), .col_order_in(col_order), .scan_page_in(spage),
    .scan_col_in(scol), .seg_data_out(seg), .display_off_out(off),
    .start_line_out(sline), .busy_out(busy), .in_reset_out(inrst));
  host_bus_model u_host (.clk_in(clk), .sel_a_n_out(sa), .sel_b_n_out(sb),
    .sel_c_out(sc), .rs_out(rs), .rw_out(rw), .strobe_out(strb), .bus_out(bus),
    .dev_data_in(dout), .dev_oe_n_in(oe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input byte_t exp, input byte_t got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic acc(input logic s, input logic w, input byte_t d);
    u_host.access(3'h1, s, w, d, q);
  endtask : acc
  task automatic rdy();
    logic ok;
    u_host.wait_ready(ok);
    if (!ok) begin
      miscompares++;
      wrap_up();
    end
  endtask : rdy
  task automatic cmd(input byte_t d);
    acc(1'b0, 1'b0, d);
    rdy();
  endtask : cmd
  task automatic t_power();
    acc(1'b0, 1'b1, 8'h00);
    check("status", 8'h30, q & 8'h7F);
    check("reset", 8'h01, {7'h0, inrst});
    check("busy", 8'h01, {7'h0, busy});
    acc(1'b0, 1'b0, 8'hC7);
    check("line", 8'h00, {2'h0, sline});
    check("off", 8'h01, {7'h0, off});
    init_n <= 1'b1;
    rdy();
    check("reset", 8'h00, {7'h0, inrst});
    check("busy", 8'h00, {7'h0, busy});
    acc(1'b0, 1'b1, 8'h00);
    check("status", 8'h20, q);
    $display("power test done");
  endtask : t_power
  task automatic t_instr();
    logic [2:0] nsel [3] = '{3'h5, 3'h3, 3'h0};
    cmd(8'h3F);
    check("off", 8'h00, {7'h0, off});
    acc(1'b0, 1'b1, 8'h00);
    check("status", 8'h00, q);
    acc(1'b0, 1'b0, 8'hC5);
    check("busy", 8'h01, {7'h0, busy});
    rdy();
    check("line", 8'h05, {2'h0, sline});
    for (int i = 0; i < 3; i++) begin
      u_host.access(nsel[i], 1'b0, 1'b0, 8'hC9, q);
      check("line", 8'h05, {2'h0, sline});
    end
    check("oe_n", 8'h01, {7'h0, oe_n});
    $display("instruction test done");
  endtask : t_instr
  task automatic t_data();
    cmd(8'hBB);
    cmd(8'h4A);
    acc(1'b1, 1'b0, 8'h5A);
    check("busy", 8'h01, {7'h0, busy});
    rdy();
    acc(1'b1, 1'b0, 8'hA5);
    rdy();
    spage <= 3'h3;
    scol <= 6'h0A;
    repeat (3) @(posedge clk);
    check("seg", 8'h5A, seg);
    col_order <= 1'b0;
    scol <= 6'h35;
    repeat (3) @(posedge clk);
    check("seg", 8'h5A, seg);
    col_order <= 1'b1;
    cmd(8'h4A);
    acc(1'b1, 1'b1, 8'h00);
    acc(1'b1, 1'b1, 8'h00);
    check("read", 8'h5A, q);
    acc(1'b1, 1'b1, 8'h00);
    check("read", 8'hA5, q);
    $display("data test done");
  endtask : t_data
  task automatic t_burst();
    cmd(8'hB9);
    cmd(8'h40);
    // Back to back without polling busy: each write leaves the FIFO before the next arrives
    for (int i = 0; i < 16; i++) acc(1'b1, 1'b0, 8'h10 + 8'(i));
    rdy();
    cmd(8'h40);
    acc(1'b1, 1'b1, 8'h00);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 1'b1, 8'h00);
      check("burst", 8'h10 + 8'(i), q);
    end
    $display("burst test done");
  endtask : t_burst
  task automatic t_init();
    cmd(8'h40);
    spage <= 3'h1;
    scol <= 6'h00;
    init_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("off", 8'h01, {7'h0, off});
    check("reset", 8'h01, {7'h0, inrst});
    check("line", 8'h00, {2'h0, sline});
    check("seg", 8'h00, seg);
    acc(1'b0, 1'b1, 8'h00);
    check("status", 8'h30, q & 8'h7F);
    acc(1'b1, 1'b0, 8'hEE);
    init_n <= 1'b1;
    rdy();
    cmd(8'h3F);
    cmd(8'h40);
    acc(1'b1, 1'b1, 8'h00);
    acc(1'b1, 1'b1, 8'h00);
    check("read", 8'h10, q);
    $display("init test done");
  endtask : t_init
  initial begin
    rst_n = 1'b0;
    init_n = 1'b0;
    col_order = 1'b1;
    spage = 3'h0;
    scol = 6'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_instr();
    t_data();
    t_burst();
    t_init();
    wrap_up();
  end
endmodule : lcd_host_port_tb_top
